// ### core/pmec_irst.sv
`timescale 1ns/1ps
module pmec_irst import pmec_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    output logic irst_o,
    output logic done_o
);
    pmec_rst_e state_reg;
    logic [3:0] cnt_reg;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= PMEC_ST_RUN;
            cnt_reg <= 4'h0;
        end
        else
        begin
            case (state_reg)
                PMEC_ST_RUN:
                begin
                    if (start_i)
                    begin
                        state_reg <= PMEC_ST_RESET;
                        cnt_reg <= PMEC_IRST_CYCLES - 4'h1;
                    end
                end
                PMEC_ST_RESET:
                begin
                    if (cnt_reg == 4'h0)
                    begin
                        state_reg <= PMEC_ST_DONE;
                    end
                    else
                    begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                PMEC_ST_DONE:
                begin
                    state_reg <= PMEC_ST_RUN;
                end
                default:
                begin
                    state_reg <= PMEC_ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irst_o <= 1'b0;
            done_o <= 1'b0;
        end
        else
        begin
            irst_o <= (state_reg == PMEC_ST_RUN) ? start_i : (state_reg == PMEC_ST_RESET && cnt_reg != 4'h0);
            done_o <= (state_reg == PMEC_ST_RESET) && (cnt_reg == 4'h0);
        end
    end
endmodule

// ### core/pmec_sync.sv
`timescale 1ns/1ps
module pmec_sync import pmec_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta_reg;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_reg <= 1'b0;
            q_o <= 1'b0;
        end
        else
        begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule

// ### core/pmec_top.sv
`timescale 1ns/1ps
module pmec_top import pmec_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    input wire logic sw_rst_i,
    input wire logic wake_pulse_i,
    input wire logic eeprom_skip_reset_bit_i,
    input wire logic eeprom_valid_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    output logic pm_event_pin_o,
    output logic internal_reset_o,
    output logic reinit_needed_o,
    output logic [1:0] power_state_o
);
    pmec_wb_req_s req;
    logic por_q;
    logic pm_event_flag_reg;
    logic pm_event_output_enable_reg;
    logic eeprom_skip_reset_bit_reg;
    logic [1:0] power_state_field_reg;
    logic [1:0] power_state_field_next;
    logic irst_start;
    logic irst_pulse;
    logic irst_done;
    logic cfg_rst;
    logic pm_event_flag_next;
    logic pm_event_output_enable_next;
    logic hit_pwr;
    logic hit_ctrl;
    logic hit_any;
    logic wr_pwr;
    logic clr_flag;
    logic wr_ctrl;
    logic valid_req;
    logic [31:0] rd_data;

    assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, adr: adr_i, sel: sel_i, dat: dat_i};

    pmec_sync u_por_sync
    (
        .clk_i(clk_i),
        .rst_i(1'b0),
        .d_i(por_i),
        .q_o(por_q)
    );

    // Address decode shared by bus answer and register logic
    assign hit_pwr = pmec_hit(req.adr, PMEC_ADDR_PWR);
    assign hit_ctrl = pmec_hit(req.adr, PMEC_ADDR_CTRL);
    assign hit_any = hit_pwr || hit_ctrl;
    assign valid_req = req.cyc && req.stb && !ack_o && !err_o;
    assign wr_pwr = valid_req && req.we && hit_pwr;
    assign wr_ctrl = valid_req && req.we && hit_ctrl;
    assign clr_flag = wr_pwr && req.sel[1] && req.dat[PMEC_FLAG_BIT];
    assign cfg_rst = rst_i || sw_rst_i || irst_pulse;

    // Event sets the flag and wins over a same-cycle clear
    always_comb
    begin
        pm_event_flag_next = pm_event_flag_reg;
        if (wake_pulse_i)
        begin
            pm_event_flag_next = 1'b1;
        end
        else if (clr_flag)
        begin
            pm_event_flag_next = 1'b0;
        end
    end

    // Flag touched only by power-up reset, event and write-one
    always_ff @(posedge clk_i)
    begin
        if (por_q)
        begin
            pm_event_flag_reg <= PMEC_FLAG_RST;
        end
        else
        begin
            pm_event_flag_reg <= pm_event_flag_next;
        end
    end

    // Enable written through byte lane 1
    always_comb
    begin
        pm_event_output_enable_next = pm_event_output_enable_reg;
        if (wr_pwr && req.sel[1])
        begin
            pm_event_output_enable_next = req.dat[PMEC_EN_BIT];
        end
    end

    // Enable survives hardware and software reset
    always_ff @(posedge clk_i)
    begin
        if (por_q)
        begin
            pm_event_output_enable_reg <= PMEC_EN_RST;
        end
        else
        begin
            pm_event_output_enable_reg <= pm_event_output_enable_next;
        end
    end

    // Skip bit loaded from serial configuration memory
    always_ff @(posedge clk_i)
    begin
        if (por_q)
        begin
            eeprom_skip_reset_bit_reg <= 1'b0;
        end
        else if (eeprom_valid_i)
        begin
            eeprom_skip_reset_bit_reg <= eeprom_skip_reset_bit_i;
        end
    end

    // Power state written through byte lane 0
    always_comb
    begin
        power_state_field_next = power_state_field_reg;
        if (wr_pwr && req.sel[0])
        begin
            power_state_field_next = req.dat[PMEC_PS_LO +: 2];
        end
    end

    // Commanded D3 to D0 change decides on internal reset
    always_comb
    begin
        irst_start = 1'b0;
        if ((power_state_field_reg == PMEC_D3) && (power_state_field_next == PMEC_D0))
        begin
            if (eeprom_skip_reset_bit_reg)
            begin
                irst_start = 1'b0;
            end
            else
            begin
                irst_start = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (por_q || cfg_rst)
        begin
            power_state_field_reg <= PMEC_PS_RST;
        end
        else
        begin
            power_state_field_reg <= power_state_field_next;
        end
    end

    pmec_irst u_irst
    (
        .clk_i(clk_i),
        .rst_i(por_q || rst_i),
        .start_i(irst_start),
        .irst_o(irst_pulse),
        .done_o(irst_done)
    );

    // Host must reinitialise after internal reset
    always_ff @(posedge clk_i)
    begin
        if (por_q || rst_i)
        begin
            reinit_needed_o <= 1'b0;
        end
        else if (irst_done)
        begin
            reinit_needed_o <= 1'b1;
        end
        else if (wr_ctrl && req.sel[0] && req.dat[0])
        begin
            reinit_needed_o <= 1'b0;
        end
    end

    always_comb
    begin
        rd_data = 32'h0000_0000;
        if (hit_pwr)
        begin
            rd_data[PMEC_FLAG_BIT] = pm_event_flag_reg;
            rd_data[PMEC_EN_BIT] = pm_event_output_enable_reg;
            rd_data[PMEC_SKIP_BIT] = eeprom_skip_reset_bit_reg;
            rd_data[PMEC_PS_LO +: 2] = power_state_field_reg;
        end
        else if (hit_ctrl)
        begin
            rd_data[0] = reinit_needed_o;
        end
    end

    // Wishbone answer one cycle after request
    always_ff @(posedge clk_i)
    begin
        if (rst_i || por_q)
        begin
            ack_o <= 1'b0;
        end
        else
        begin
            ack_o <= valid_req && hit_any;
        end
    end

    // Unmapped address answered by error, no effect
    always_ff @(posedge clk_i)
    begin
        if (rst_i || por_q)
        begin
            err_o <= 1'b0;
        end
        else
        begin
            err_o <= valid_req && !hit_any;
        end
    end

    // Read data stands only with the read answer
    always_ff @(posedge clk_i)
    begin
        if (rst_i || por_q)
        begin
            dat_o <= 32'h0000_0000;
        end
        else
        begin
            dat_o <= (valid_req && !req.we) ? rd_data : 32'h0000_0000;
        end
    end

    // Event pin follows flag and enable
    always_ff @(posedge clk_i)
    begin
        if (por_q)
        begin
            pm_event_pin_o <= 1'b0;
        end
        else
        begin
            pm_event_pin_o <= pm_event_flag_reg && pm_event_output_enable_reg;
        end
    end

    // Internal reset pulse shown registered
    always_ff @(posedge clk_i)
    begin
        if (por_q)
        begin
            internal_reset_o <= 1'b0;
        end
        else
        begin
            internal_reset_o <= irst_pulse;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (por_q)
        begin
            power_state_o <= PMEC_PS_RST;
        end
        else
        begin
            power_state_o <= power_state_field_reg;
        end
    end
endmodule

// ### shared/pmec_pkg.sv
package pmec_pkg;
    // Register map, byte addresses on the Wishbone word bus
    localparam logic [7:0] PMEC_ADDR_PWR = 8'h08;
    localparam logic [7:0] PMEC_ADDR_CTRL = 8'h0C;
    // Field positions of the power control/status register
    localparam int PMEC_FLAG_BIT = 15;
    localparam int PMEC_EN_BIT = 8;
    localparam int PMEC_SKIP_BIT = 3;
    localparam int PMEC_PS_LO = 0;
    // Reset values
    localparam logic [1:0] PMEC_PS_RST = 2'h0;
    localparam logic PMEC_FLAG_RST = 1'b0;
    localparam logic PMEC_EN_RST = 1'b0;
    // Length of the internal reset pulse in cycles
    localparam logic [3:0] PMEC_IRST_CYCLES = 4'h4;
    // Power state encodings
    localparam logic [1:0] PMEC_D0 = 2'h0;
    localparam logic [1:0] PMEC_D1 = 2'h1;
    localparam logic [1:0] PMEC_D2 = 2'h2;
    localparam logic [1:0] PMEC_D3 = 2'h3;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } pmec_wb_req_s;

    typedef enum logic [2:0] {
        PMEC_ST_RUN = 3'b001,
        PMEC_ST_RESET = 3'b010,
        PMEC_ST_DONE = 3'b100
    } pmec_rst_e;

    function automatic logic pmec_hit(input logic [7:0] adr, input logic [7:0] base);
        pmec_hit = (adr[7:2] == base[7:2]);
    endfunction
endpackage

// ### tb/pmec_monitor.sv
`timescale 1ns/1ps
module pmec_monitor import pmec_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    input wire logic wake_pulse_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic err_o,
    input wire logic pm_event_pin_o,
    input wire logic internal_reset_o,
    input wire logic reinit_needed_o,
    input wire logic [1:0] power_state_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (por_i || rst_i);
    wire tk = cyc_i && stb_i && !ack_o && !err_o;
    wire m08 = adr_i[7:2] == PMEC_ADDR_PWR[7:2];
    wire map = m08 || adr_i[7:2] == PMEC_ADDR_CTRL[7:2];
    wire w08 = tk && we_i && m08;
    wire go_d0 = w08 && dat_i[1:0] == PMEC_D0 && power_state_o == PMEC_D3;
    property p_ack; tk && map |=> ack_o && !err_o; endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_err; tk && !map |=> err_o && !ack_o; endproperty
    a_err: assert property (p_err) else $error("no err");
    property p_rsv; ack_o && !we_i && m08 |-> (dat_o & 32'hFFFF_7EF4) == 0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_rise; @(posedge clk_i) disable iff (por_i)
        $rose(pm_event_pin_o) |-> $past(wake_pulse_i, 2) || $past(w08, 2); endproperty
    a_rise: assert property (p_rise) else $error("pin rose uncaused");
    property p_fall; @(posedge clk_i) disable iff (por_i) $fell(pm_event_pin_o) |-> $past(w08, 2); endproperty
    a_fall: assert property (p_fall) else $error("pin fell uncaused");
    property p_ilen; $rose(internal_reset_o) |-> internal_reset_o [*4] ##1 !internal_reset_o; endproperty
    a_ilen: assert property (p_ilen) else $error("reset pulse length");
    property p_icause; $rose(internal_reset_o) |-> $past(go_d0, 2); endproperty
    a_icause: assert property (p_icause) else $error("reset uncaused");
    property p_reinit; $fell(internal_reset_o) |-> ##[0:2] reinit_needed_o; endproperty
    a_reinit: assert property (p_reinit) else $error("reinit not flagged");
    c_pin: cover property ($rose(pm_event_pin_o));
    c_irst: cover property ($rose(internal_reset_o));
    c_err: cover property (err_o);
endmodule

bind pmec_top pmec_monitor u_mon (.clk_i, .rst_i, .por_i, .wake_pulse_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i,
    .dat_o, .ack_o, .err_o, .pm_event_pin_o, .internal_reset_o, .reinit_needed_o, .power_state_o);

// ### tb/pmec_wake_model.sv
`timescale 1ns/1ps
module pmec_wake_model
(
    input wire logic clk_i,
    input wire logic fire_i,
    input wire logic load_i,
    input wire logic skip_i,
    output logic wake_o = 1'h0,
    output logic valid_o = 1'h0,
    output logic skip_o = 1'h0
);
    // Skip line toggles while no load is offered
    always_ff @(posedge clk_i)
    begin
        wake_o <= fire_i;
        valid_o <= load_i;
        skip_o <= load_i ? skip_i : ~skip_o;
    end
endmodule

// ### tb/power_mgmt_event_control_tb.sv
`timescale 1ns/1ps
module power_mgmt_event_control_tb import pmec_pkg::*;;
    logic clk_i = 1'h0, rst_i = 1'h1, por_i = 1'h1, sw_rst_i = 1'h0, fire = 1'h0, load = 1'h0, skip = 1'h0;
    logic cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0, ack_o, err_o, be, pin, irst, reinit, wake, valid, sk;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0000_0000, dat_o, q;
    logic [1:0] ps;
    int fail_count = 0, tests_run = 0, cycles = 0, n;
    pmec_top dut (.clk_i, .rst_i, .por_i, .sw_rst_i, .wake_pulse_i(wake), .eeprom_skip_reset_bit_i(sk),
        .eeprom_valid_i(valid), .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'hF), .dat_i, .dat_o, .ack_o, .err_o,
        .pm_event_pin_o(pin), .internal_reset_o(irst), .reinit_needed_o(reinit), .power_state_o(ps));
    pmec_wake_model far (.clk_i, .fire_i(fire), .load_i(load), .skip_i(skip), .wake_o(wake),
        .valid_o(valid), .skip_o(sk));
    initial forever #50 clk_i = ~clk_i;
    task automatic report_and_stop();
        if (fail_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            report_and_stop();
        end
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Classic cycle held until ack or err is sampled
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'h1 && err_o !== 1'h1);
        q = dat_o;
        be = err_o;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
    endtask
    task automatic t_event();
        bus(1'h0, PMEC_ADDR_PWR, 32'h0);
        chk("reset value", q, 32'h0);
        bus(1'h0, 8'h10, 32'h0);
        chk("unmapped", be, 32'h1);
        bus(1'h1, PMEC_ADDR_PWR, 32'h0000_0100);
        fire <= 1'h1;
        @(posedge clk_i);
        fire <= 1'h0;
        repeat (4) @(posedge clk_i);
        chk("pin up", pin, 32'h1);
        rst_i <= 1'h1;
        sw_rst_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        sw_rst_i <= 1'h0;
        bus(1'h0, PMEC_ADDR_PWR, 32'h0);
        chk("kept", q, 32'h0000_8100);
        chk("pin kept", pin, 32'h1);
        bus(1'h1, PMEC_ADDR_PWR, 32'h0);
        bus(1'h0, PMEC_ADDR_PWR, 32'h0);
        chk("zero write", q, 32'h0000_8000);
        chk("pin gated", pin, 32'h0);
        bus(1'h1, PMEC_ADDR_PWR, 32'h0000_8100);
        bus(1'h0, PMEC_ADDR_PWR, 32'h0);
        chk("flag clear", q, 32'h0000_0100);
        chk("pin off", pin, 32'h0);
    endtask
    task automatic t_power();
        for (int s = 0; s < 4; s++)
        begin
            bus(1'h1, PMEC_ADDR_PWR, 32'hFFFF_7EF4 | s);
            bus(1'h0, PMEC_ADDR_PWR, 32'h0);
            chk("state", q, s);
            chk("state out", ps, s);
        end
        bus(1'h1, PMEC_ADDR_PWR, 32'h0);
        repeat (8) if (irst !== 1'h1) @(posedge clk_i);
        chk("irst", irst, 32'h1);
        repeat (8) @(posedge clk_i);
        chk("reinit", reinit, 32'h1);
        bus(1'h0, PMEC_ADDR_CTRL, 32'h0);
        chk("reinit reg", q, 32'h1);
        bus(1'h1, PMEC_ADDR_CTRL, 32'h1);
        bus(1'h0, PMEC_ADDR_CTRL, 32'h0);
        chk("reinit off", q, 32'h0);
    endtask
    task automatic t_skip();
        skip <= 1'h1;
        load <= 1'h1;
        repeat (2) @(posedge clk_i);
        load <= 1'h0;
        bus(1'h0, PMEC_ADDR_PWR, 32'h0);
        chk("skip", q, 32'h0000_0008);
        bus(1'h1, PMEC_ADDR_PWR, 32'h3);
        bus(1'h1, PMEC_ADDR_PWR, 32'h0);
        n = 0;
        repeat (10) @(posedge clk_i) n += int'(irst === 1'h1);
        chk("no irst", n, 32'h0);
    endtask
    initial
    begin
        repeat (6) @(posedge clk_i);
        por_i <= 1'h0;
        rst_i <= 1'h0;
        repeat (3) @(posedge clk_i);
        t_event();
        t_power();
        t_skip();
        report_and_stop();
    end
endmodule
